// *** hw/aux_gpio_pkg.sv ***
`default_nettype none
package aux_gpio_pkg;

    localparam int NUM_PINS = 10;
    localparam int NUM_RING = 3;
    localparam int RING_CNT_W = 24;

    // Pin slots: 1.0, 1.1, 1.2, LED pin, 1.4, 1.5, 1.6, 1.7, 5.0, 5.2.
    localparam int PIN_1_0 = 0;
    localparam int PIN_1_1 = 1;
    localparam int PIN_1_2 = 2;
    localparam int PIN_LED = 3;
    localparam int PIN_1_4 = 4;
    localparam int PIN_1_5 = 5;
    localparam int PIN_1_6 = 6;
    localparam int PIN_1_7 = 7;
    localparam int PIN_5_0 = 8;
    localparam int PIN_5_2 = 9;

    localparam logic [7:0] LOGICAL_DEVICE_NUMBER = 8'h08;

    // Register indices; the byte address is four times the index.
    localparam logic [NUM_PINS-1:0][7:0] CFG_INDEX = {
        8'hCA, 8'hC8, 8'hE7, 8'hE6, 8'hE5, 8'hE4, 8'hE3, 8'hE2, 8'hE1, 8'hE0};
    localparam logic [NUM_PINS-1:0][7:0] CFG_RESET = {
        8'h09, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
    localparam logic [NUM_PINS-1:0][7:0] CFG_MASK = {
        8'hBB, 8'hBB, 8'h8F, 8'h8F, 8'h8F, 8'h8F, 8'h8F, 8'h9F, 8'h9F, 8'h8F};
    localparam logic [7:0] RING_SEL_INDEX = 8'hC6;
    localparam logic [7:0] RING_SEL_RESET = 8'h00;
    localparam logic [7:0] RING_SEL_MASK = 8'h07;
    localparam logic [7:0] DATA_INDEX = 8'hF0;
    localparam logic [7:0] EDGE_INDEX = 8'hF1;
    localparam logic [7:0] LDN_INDEX = 8'hF2;
    localparam logic [NUM_PINS-1:0] DATA_RESET = 10'h000;

    // Field positions inside a pin configuration register.
    localparam int DIR_BIT = 0;
    localparam int POL_BIT = 1;
    localparam int GRP1_BIT = 2;
    localparam int FUNC_LO = 3;
    localparam int FUNC_HI = 4;
    localparam int GRP2_BIT = 5;
    localparam int DRV_BIT = 7;

    localparam logic [1:0] FN_00 = 2'h0;
    localparam logic [1:0] FN_01 = 2'h1;
    localparam logic [1:0] FN_10 = 2'h2;
    localparam logic [1:0] FN_11 = 2'h3;

    // Ring wake filter: a train at 15 Hz or faster keeps the output low.
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint RING_GAP_NS = 66666666;
    localparam int RING_HOLD_CYCLES = int'(RING_GAP_NS / CLK_PERIOD_NS);

endpackage
`default_nettype wire

// *** hw/ring_wake_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
module ring_wake_filter
    import aux_gpio_pkg::*;
#(
    parameter int HOLD_CYCLES = RING_HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic filterEn,
    input wire logic ringN,
    output logic ringOutN
);

    localparam logic [RING_CNT_W-1:0] HOLD_LOAD = RING_CNT_W'(HOLD_CYCLES);

    logic prev_reg;
    logic [RING_CNT_W-1:0] cnt_reg;
    logic [RING_CNT_W-1:0] cnt_next;
    logic outN_next;

    wire fall = prev_reg & ~ringN;
    wire toggle = prev_reg ^ ringN;
    wire running = (cnt_reg != '0);

    // A falling edge starts the pulse; later toggles inside the gap keep it going.
    assign cnt_next = !filterEn ? '0 :
                      (fall || (toggle && running)) ? HOLD_LOAD :
                      running ? cnt_reg - 1'b1 : cnt_reg;
    assign outN_next = filterEn ? (cnt_next == '0) : ~fall;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prev_reg <= 1'b1;
            cnt_reg <= '0;
            ringOutN <= 1'b1;
        end else begin
            prev_reg <= ringN;
            cnt_reg <= cnt_next;
            ringOutN <= outN_next;
        end
    end

endmodule
`default_nettype wire

// *** hw/aux_gpio_pin_config.sv ***
`timescale 1ns/10ps
`default_nettype none
module aux_gpio_pin_config
    import aux_gpio_pkg::*;
#(
    parameter int RING_HOLD = RING_HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_PINS-1:0] gpioIn,
    output logic [NUM_PINS-1:0] gpioOut,
    output logic [NUM_PINS-1:0] gpioOe,
    input wire logic ringInOneN,
    input wire logic ringInTwoN,
    input wire logic sysMgmtIrqOutN,
    input wire logic watchdogOut,
    input wire logic kbcPortLine17,
    input wire logic ledDrive,
    input wire logic infraredTxSecond,
    input wire logic floppyMotorOn1N,
    input wire logic floppyDriveSel1N,
    input wire logic driveDensitySel1,
    output logic combinedIrq1,
    output logic combinedIrq2,
    output logic edgeIrq1,
    output logic edgeIrq2,
    output logic ringIndicateN,
    output logic infraredRxSecond,
    output logic pciClkOut,
    output logic irq14Req,
    output logic irq8Req
);

    // Pin and ring inputs come from outside the clock domain.
    localparam int NUM_SYNC = NUM_PINS + 2;

    logic [NUM_SYNC-1:0] sync1_reg;
    logic [NUM_SYNC-1:0] sync2_reg;
    logic [NUM_SYNC-1:0] sync3_reg;
    logic [NUM_SYNC-1:0] stable_reg;
    logic [NUM_PINS-1:0][7:0] cfg_reg;
    logic [7:0] ringSel_reg;
    logic [NUM_PINS-1:0] data_reg;
    logic [1:0] edge_reg;
    logic [1:0] edge_next;
    logic [NUM_PINS-1:0] logicPrev_reg;
    logic [NUM_RING-1:0] ringOutN;
    logic [NUM_PINS-1:0] pinLogic;
    logic [NUM_PINS-1:0] isGpio;
    logic [NUM_PINS-1:0] altDrive;
    logic [NUM_PINS-1:0] altVal;
    logic [NUM_PINS-1:0] driveEn;
    logic [NUM_PINS-1:0] driveVal;
    logic [NUM_PINS-1:0] cfgHit;
    logic [NUM_PINS-1:0] grp1Act;
    logic [NUM_PINS-1:0] grp2Act;
    logic [NUM_RING-1:0] ringSrcN;

    wire [1:0] fn11 = cfg_reg[PIN_1_1][FUNC_HI:FUNC_LO];
    wire [1:0] fn12 = cfg_reg[PIN_1_2][FUNC_HI:FUNC_LO];
    wire [1:0] fn50 = cfg_reg[PIN_5_0][FUNC_HI:FUNC_LO];
    wire [1:0] fn52 = cfg_reg[PIN_5_2][FUNC_HI:FUNC_LO];

    // Input synchronisers; a change is taken once stages two and three agree.
    wire [NUM_SYNC-1:0] rawIn = {ringInTwoN, ringInOneN, gpioIn};

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            sync3_reg <= '1;
        end else begin
            sync1_reg <= rawIn;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    genvar s;
    generate
        for (s = 0; s < NUM_SYNC; s++) begin : g_stable
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    stable_reg[s] <= 1'b1;
                end else if (sync2_reg[s] == sync3_reg[s]) begin
                    stable_reg[s] <= sync3_reg[s];
                end
            end
        end
    endgenerate

    // APB decode: zero-wait answer, one access phase cycle.
    // The read word is captured at setup, so the access cycle never has to wait.
    wire [9:0] regIndex = paddr[11:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire setup = psel & ~penable;
    wire wrEn = psel & penable & pready & pwrite;
    wire ringSelHit = aligned && (regIndex == {2'h0, RING_SEL_INDEX});
    wire dataHit = aligned && (regIndex == {2'h0, DATA_INDEX});
    wire edgeHit = aligned && (regIndex == {2'h0, EDGE_INDEX});
    wire ldnHit = aligned && (regIndex == {2'h0, LDN_INDEX});
    wire anyHit = (|cfgHit) | ringSelHit | dataHit | edgeHit | ldnHit;

    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (cfgHit[i]) begin
                rdMux = {24'h00_0000, cfg_reg[i]};
            end
        end
        if (ringSelHit) begin
            rdMux = {24'h00_0000, ringSel_reg};
        end
        if (dataHit) begin
            rdMux = {22'h00_0000, pinLogic};
        end
        if (edgeHit) begin
            rdMux = {30'h0000_0000, edge_reg};
        end
        if (ldnHit) begin
            rdMux = {24'h00_0000, LOGICAL_DEVICE_NUMBER};
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~anyHit;
            prdata <= (setup && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    // Pin configuration registers with masked reserved bits.
    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p++) begin : g_cfg
            assign cfgHit[p] = aligned && (regIndex == {2'h0, CFG_INDEX[p]});
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    cfg_reg[p] <= CFG_RESET[p];
                end else if (wrEn && cfgHit[p]) begin
                    cfg_reg[p] <= pwdata[7:0] & CFG_MASK[p];
                end
            end
            assign pinLogic[p] = stable_reg[p] ^ cfg_reg[p][POL_BIT];
            assign driveEn[p] = isGpio[p] ? ~cfg_reg[p][DIR_BIT] : altDrive[p];
            assign driveVal[p] = (isGpio[p] ? data_reg[p] : altVal[p])
                                 ^ cfg_reg[p][POL_BIT];
            if (p < PIN_5_0) begin : g_grp1
                assign grp1Act[p] = pinLogic[p] & cfg_reg[p][GRP1_BIT];
                assign grp2Act[p] = 1'b0;
            end else begin : g_grp2
                assign grp1Act[p] = 1'b0;
                assign grp2Act[p] = pinLogic[p] & cfg_reg[p][GRP2_BIT];
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ringSel_reg <= RING_SEL_RESET;
            data_reg <= DATA_RESET;
        end else if (wrEn && ringSelHit) begin
            ringSel_reg <= pwdata[7:0] & RING_SEL_MASK;
        end else if (wrEn && dataHit) begin
            data_reg <= pwdata[NUM_PINS-1:0];
        end
    end

    // Function selection per pin; reserved codes fall back to GPIO.
    assign isGpio[PIN_1_0] = ~cfg_reg[PIN_1_0][FUNC_LO];
    assign isGpio[PIN_1_1] = (fn11 == FN_00) || (fn11 == FN_11);
    assign isGpio[PIN_1_2] = (fn12 == FN_00);
    assign isGpio[PIN_LED] = ~cfg_reg[PIN_LED][FUNC_LO];
    assign isGpio[PIN_1_4] = ~cfg_reg[PIN_1_4][FUNC_LO];
    assign isGpio[PIN_1_5] = ~cfg_reg[PIN_1_5][FUNC_LO];
    assign isGpio[PIN_1_6] = ~cfg_reg[PIN_1_6][FUNC_LO];
    assign isGpio[PIN_1_7] = ~cfg_reg[PIN_1_7][FUNC_LO];
    assign isGpio[PIN_5_0] = (fn50 == FN_10) || (fn50 == FN_11);
    assign isGpio[PIN_5_2] = (fn52 == FN_01);

    // Alternate outputs drive the pin whatever the direction bit says.
    assign altDrive[PIN_1_0] = 1'b1;
    assign altDrive[PIN_1_1] = 1'b0;
    assign altDrive[PIN_1_2] = (fn12 == FN_01) || (fn12 == FN_10);
    assign altDrive[PIN_LED] = 1'b1;
    assign altDrive[PIN_1_4] = 1'b0;
    assign altDrive[PIN_1_5] = 1'b1;
    assign altDrive[PIN_1_6] = 1'b1;
    assign altDrive[PIN_1_7] = 1'b1;
    assign altDrive[PIN_5_0] = 1'b0;
    assign altDrive[PIN_5_2] = (fn52 == FN_00) || (fn52 == FN_11);

    assign altVal[PIN_1_0] = sysMgmtIrqOutN;
    assign altVal[PIN_1_1] = 1'b0;
    assign altVal[PIN_1_2] = (fn12 == FN_01) ? watchdogOut : kbcPortLine17;
    assign altVal[PIN_LED] = ledDrive;
    assign altVal[PIN_1_4] = 1'b0;
    assign altVal[PIN_1_5] = infraredTxSecond;
    assign altVal[PIN_1_6] = floppyMotorOn1N;
    assign altVal[PIN_1_7] = floppyDriveSel1N;
    assign altVal[PIN_5_0] = 1'b0;
    assign altVal[PIN_5_2] = (fn52 == FN_00) ? driveDensitySel1 : sysMgmtIrqOutN;

    // Open drain only ever pulls low; a high level releases the pin.
    wire [NUM_PINS-1:0] odSel = {cfg_reg[9][DRV_BIT], cfg_reg[8][DRV_BIT],
        cfg_reg[7][DRV_BIT], cfg_reg[6][DRV_BIT], cfg_reg[5][DRV_BIT],
        cfg_reg[4][DRV_BIT], cfg_reg[3][DRV_BIT], cfg_reg[2][DRV_BIT],
        cfg_reg[1][DRV_BIT], cfg_reg[0][DRV_BIT]};
    wire [NUM_PINS-1:0] oeNext = driveEn & (~odSel | ~driveVal);
    wire [NUM_PINS-1:0] outNext = driveVal & ~odSel;

    // Either-edge interrupts watch the polarity-adjusted level.
    wire [1:0] edgeSel = {fn12 == FN_11, fn11 == FN_10};
    wire [NUM_PINS-1:0] logicChg = pinLogic ^ logicPrev_reg;
    wire [1:0] edgeSet = edgeSel & {logicChg[PIN_1_2], logicChg[PIN_1_1]};
    wire [1:0] edgeClr = (wrEn && edgeHit) ? pwdata[1:0] : 2'h0;
    // A new edge in the cycle of its clear survives, so no event is lost.
    assign edge_next = edgeSet | (edge_reg & ~edgeClr);

    // Ring sources: pin 1.1 only counts while it is the ring input.
    assign ringSrcN = {stable_reg[NUM_PINS+1], stable_reg[NUM_PINS],
                       (fn11 == FN_01) ? stable_reg[PIN_1_1] : 1'b1};

    genvar r;
    generate
        for (r = 0; r < NUM_RING; r++) begin : g_ring
            ring_wake_filter #(
                .HOLD_CYCLES(RING_HOLD)
            ) u_filter (
                .core_clk(core_clk),
                .rstn(rstn),
                .filterEn(ringSel_reg[r]),
                .ringN(ringSrcN[r]),
                .ringOutN(ringOutN[r])
            );
        end
    endgenerate

    // The previous level starts at the idle pin level, so leaving reset makes no false edge.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            logicPrev_reg <= '1;
        end else begin
            logicPrev_reg <= pinLogic;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            edge_reg <= 2'h0;
        end else begin
            edge_reg <= edge_next;
        end
    end

    // Side-band results are registered so that every port leaves a flip-flop.
    wire irq1_next = |grp1Act;
    wire irq2_next = |grp2Act;
    wire ring_next = &ringOutN;
    wire irRx_next = cfg_reg[PIN_1_4][FUNC_LO] & pinLogic[PIN_1_4];
    wire pciClk_next = (fn50 == FN_00) & pinLogic[PIN_5_0];
    wire irq14_next = (fn50 == FN_01) & pinLogic[PIN_5_0];
    wire irq8_next = (fn52 == FN_10) & pinLogic[PIN_5_2];

    // Pin drive is registered; a configuration write reaches the pin one cycle later.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gpioOut <= '0;
            gpioOe <= '0;
        end else begin
            gpioOut <= outNext;
            gpioOe <= oeNext;
        end
    end

    // The edge outputs follow the next latch value, so they rise with the latch itself.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            combinedIrq1 <= 1'b0;
            combinedIrq2 <= 1'b0;
            edgeIrq1 <= 1'b0;
            edgeIrq2 <= 1'b0;
            ringIndicateN <= 1'b1;
        end else begin
            combinedIrq1 <= irq1_next;
            combinedIrq2 <= irq2_next;
            edgeIrq1 <= edge_next[0];
            edgeIrq2 <= edge_next[1];
            ringIndicateN <= ring_next;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            infraredRxSecond <= 1'b0;
            pciClkOut <= 1'b0;
            irq14Req <= 1'b0;
            irq8Req <= 1'b0;
        end else begin
            infraredRxSecond <= irRx_next;
            pciClkOut <= pciClk_next;
            irq14Req <= irq14_next;
            irq8Req <= irq8_next;
        end
    end

endmodule
`default_nettype wire

// *** test/aux_gpio_pin_config_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module aux_gpio_pin_config_props
    import aux_gpio_pkg::*;
#(
    parameter int RING_HOLD = RING_HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_PINS-1:0] gpioOe,
    input wire logic edgeIrq1,
    input wire logic edgeIrq2,
    input wire logic ringIndicateN
);
    // The ring select is shadowed here, since plain and filtered ring modes differ at the port.
    logic [2:0] ringSelReg;
    wire setup = psel && !penable;
    wire wrDone = psel && penable && pready && pwrite;
    wire clr1 = wrDone && paddr == 12'h3C4 && pwdata[0];
    wire clr2 = wrDone && paddr == 12'h3C4 && pwdata[1];
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ringSelReg <= 3'h0;
        end else if (wrDone && paddr == 12'h318) begin
            ringSelReg <= pwdata[2:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    AST_RESET_DRIVE: assert property ($rose(rstn) |=> gpioOe == 10'h020)
        else $error("pin drive after reset is wrong");
    AST_APB_ANSWER: assert property (setup |=> pready ##1 !pready)
        else $error("access answer is wrong");
    AST_DEVICE_NUMBER: assert property (setup && !pwrite && paddr == 12'h3C8
        |=> prdata == 32'h8 && !pslverr) else $error("device number read is wrong");
    AST_UNMAPPED: assert property (setup && paddr[1:0] != 2'h0
        |=> pslverr && prdata == 32'h0) else $error("unaligned access not refused");
    AST_EDGE_ONE: assert property ($fell(edgeIrq1) |-> $past(clr1))
        else $error("edge latch one dropped without a clear");
    AST_EDGE_TWO: assert property ($fell(edgeIrq2) |-> $past(clr2))
        else $error("edge latch two dropped without a clear");
    AST_RING_PLAIN: assert property (!ringIndicateN && ringSelReg == 3'h0
        |=> ringIndicateN) else $error("plain ring pulse too long");
    AST_RING_HOLD: assert property (ringSelReg != 3'h0 && $fell(ringIndicateN)
        |-> !ringIndicateN [*8]) else $error("filtered ring pulse too short");
    cover property (setup && paddr == 12'h3C8);
    cover property ($fell(edgeIrq2));
    cover property (ringSelReg != 3'h0 && !ringIndicateN);
endmodule
bind aux_gpio_pin_config aux_gpio_pin_config_props #(.RING_HOLD(RING_HOLD)) u_props (
    .core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .gpioOe, .edgeIrq1, .edgeIrq2, .ringIndicateN);
`default_nettype wire

// *** test/aux_gpio_pin_config_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module aux_gpio_pin_config_tb;
    import aux_gpio_pkg::*;
    localparam int RH = 20;
    logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, ringInOneN, ringInTwoN;
    logic combinedIrq1, combinedIrq2, edgeIrq1, edgeIrq2, ringIndicateN;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [9:0] gpioIn, gpioOut, gpioOe, w;
    logic [7:0] src, v;
    logic [3:0] alt;
    logic [32:0] expQ[$];
    int nErrors, nTests, seed, c;
    // Select codes below 8 name a source bit, 8 to 11 an input-side alternate output.
    int tSlot[13] = '{0, 2, 2, 3, 5, 6, 7, 9, 9, 4, 8, 8, 9};
    int tSel[13] = '{7, 6, 5, 4, 3, 2, 1, 0, 7, 11, 10, 9, 8};
    logic [7:0] tCfg[13] = '{8'h08, 8'h08, 8'h10, 8'h08, 8'h08, 8'h08, 8'h0A, 8'h00, 8'h18,
        8'h09, 8'h01, 8'h09, 8'h13};
    logic [7:0] dCfg[5] = '{8'h00, 8'h02, 8'h80, 8'h80, 8'h01};
    logic [1:0] dExp[5] = '{2'h3, 2'h2, 2'h0, 2'h2, 2'h0};
    logic dVal[5] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1};
    logic [9:0] gIn[3] = '{10'h2AA, 10'h2AB, 10'h0AA};
    aux_gpio_pin_config #(.RING_HOLD(RH)) u_dut (.core_clk, .rstn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .gpioIn, .gpioOut, .gpioOe, .ringInOneN,
        .ringInTwoN, .sysMgmtIrqOutN(src[7]), .watchdogOut(src[6]), .kbcPortLine17(src[5]),
        .ledDrive(src[4]), .infraredTxSecond(src[3]), .floppyMotorOn1N(src[2]),
        .floppyDriveSel1N(src[1]), .driveDensitySel1(src[0]), .combinedIrq1, .combinedIrq2,
        .edgeIrq1, .edgeIrq2, .ringIndicateN, .infraredRxSecond(alt[3]), .pciClkOut(alt[2]),
        .irq14Req(alt[1]), .irq8Req(alt[0]));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        nTests++;
        if (seen !== exp) begin
            nErrors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (nErrors == 0 && nTests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    function automatic logic [11:0] ca(input int i);
        return {2'h0, CFG_INDEX[i], 2'h0};
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dd,
            input logic [32:0] e);
        int k;
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dd;
        if (!wr) expQ.push_back(e);
        @(posedge core_clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        if (k == 50) nErrors++;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
            check({pslverr, prdata}, expQ.pop_front());
        end
    end
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    // The whole sequence needs well under a thousand cycles; ten thousand means a hang.
    initial begin
        #100000;
        nErrors++;
        finish_test();
    end
    initial begin
        seed = 32'h67E54691;
        {rstn, psel, penable, pwrite, paddr, pwdata, src} = '0;
        {ringInOneN, ringInTwoN, gpioIn} = '1;
        cyc(5);
        rstn <= 1'h1;
        for (int i = 0; i < NUM_PINS; i++) begin
            apb(1'h0, ca(i), 32'h0, {25'h0, i == 5 ? 8'h00 : i == 9 ? 8'h09 : 8'h01});
        end
        apb(1'h0, 12'h3C8, 32'h0, 33'h8);
        apb(1'h0, 12'h381, 32'h0, 33'h100000000);
        apb(1'h0, 12'h7FC, 32'h0, 33'h100000000);
        for (int i = 0; i < NUM_PINS; i++) begin
            d = $random(seed);
            v = (i == 1 || i == 2) ? 8'h9F : i > 7 ? 8'hBB : 8'h8F;
            apb(1'h1, ca(i), d, 33'h0);
            apb(1'h0, ca(i), 32'h0, {25'h0, d[7:0] & v});
        end
        for (int j = 0; j < 5; j++) begin
            apb(1'h1, ca(0), {24'h0, dCfg[j]}, 33'h0);
            apb(1'h1, 12'h3C0, {31'h0, dVal[j]}, 33'h0);
            cyc(2);
            check(33'({gpioOe[0], gpioOut[0] & gpioOe[0]}), 33'(dExp[j]));
        end
        for (int i = 0; i < NUM_PINS; i++) begin
            v = (i > 7 ? 8'h20 : 8'h04) | (i == 8 ? 8'h11 : i == 9 ? 8'h09 : 8'h01);
            v[1] = i[0];
            apb(1'h1, ca(i), {24'h0, v}, 33'h0);
        end
        for (int j = 0; j < 4; j++) begin
            gpioIn <= j == 3 ? 10'($random(seed)) : gIn[j];
            cyc(8);
            w = gpioIn ^ 10'h2AA;
            apb(1'h0, 12'h3C0, 32'h0, {23'h0, w});
            check(33'({combinedIrq2, combinedIrq1}), 33'({|w[9:8], |w[7:0]}));
        end
        for (int j = 0; j < 13; j++) begin
            apb(1'h1, ca(tSlot[j]), {24'h0, tCfg[j]}, 33'h0);
            repeat (2) begin
                src <= 8'($random(seed));
                gpioIn <= 10'($random(seed));
                cyc(8);
                if (tSel[j] < 8) check(33'({gpioOe[tSlot[j]], gpioOut[tSlot[j]]}),
                    33'({1'h1, src[tSel[j]] ^ tCfg[j][1]}));
                else check(33'(alt[tSel[j] - 8]),
                    33'(gpioIn[tSlot[j]] ^ tCfg[j][1]));
            end
        end
        apb(1'h1, ca(1), 32'h11, 33'h0);
        apb(1'h1, ca(2), 32'h19, 33'h0);
        for (int j = 0; j < 2; j++) begin
            cyc(8);
            apb(1'h1, 12'h3C4, 32'h3, 33'h0);
            cyc(2);
            check(33'({edgeIrq2, edgeIrq1}), 33'h0);
            gpioIn[2:1] <= ~gpioIn[2:1];
            cyc(8);
            check(33'({edgeIrq2, edgeIrq1}), 33'h3);
        end
        apb(1'h1, ca(1), 32'h9, 33'h0);
        gpioIn[1] <= 1'h1;
        for (int j = 0; j < 3; j++) begin
            cyc(8);
            gpioIn[1] <= j != 0;
            ringInOneN <= j != 1;
            ringInTwoN <= j != 2;
            c = 0;
            repeat (16) begin
                @(posedge core_clk);
                c += int'(ringIndicateN === 1'h0);
            end
            check(33'(c), 33'h1);
            {ringInTwoN, ringInOneN, gpioIn[1]} <= 3'h7;
        end
        apb(1'h1, 12'h318, 32'h7, 33'h0);
        for (int j = 0; j < 12; j++) begin
            ringInOneN <= ~ringInOneN;
            cyc(6);
            if (j > 1) check(33'(ringIndicateN), 33'h0);
        end
        cyc(RH / 2);
        check(33'(ringIndicateN), 33'h0);
        cyc(RH);
        check(33'(ringIndicateN), 33'h1);
        rstn <= 1'h0;
        cyc(5);
        rstn <= 1'h1;
        apb(1'h0, ca(5), 32'h0, 33'h0);
        cyc(2);
        finish_test();
    end
endmodule
`default_nettype wire
